// ### src/pcm_cache_top.sv
// Purpose: direct-mapped program cache with banked memory arbitration
// Assumes: fetch, line and data requesters run on MCLK_I
// Function
// - 32 KB direct-mapped program cache
// - 256-bit lines, whole-line fills
// - hits answer next cycle, no stall
// - internal miss costs two cycles
// - external lines are cached too
// - mode comes from bits seven to five
// - 010b and 000b enable fills
// - 011b freezes, 100b forces miss
// - mode change keeps valid lines
// - software invalidate via two registers
// - rom two pages of 64-bit banks
// - ram one page, eight 32-bit banks
// - up to three accesses per cycle
// - four request sources of set widths
// - line fetch conflicts on same page
// - different pages or banks proceed together
`timescale 1ns/1ps
module pcm_cache_top #(
    parameter int CACHE_BYTES = pcm_pkg::CACHE_BYTES
) (
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic [31:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic FETCH_REQ_I,
    input wire logic [31:0] FETCH_ADDR_I,
    output logic FETCH_READY_O,
    output logic FETCH_VALID_O,
    output logic [31:0] FETCH_DATA_O,
    output logic LINE_REQ_O,
    output logic [31:0] LINE_ADDR_O,
    output logic LINE_GNT_O,
    input wire logic LINE_VALID_I,
    input wire logic [255:0] LINE_DATA_I,
    input wire logic DA_REQ_I,
    input wire logic [31:0] DA_ADDR_I,
    output logic DA_GNT_O,
    input wire logic DB_REQ_I,
    input wire logic [31:0] DB_ADDR_I,
    output logic DB_GNT_O,
    input wire logic PER_REQ_I,
    input wire logic [31:0] PER_ADDR_I,
    output logic PER_GNT_O
);
    localparam int LINE_BYTES = pcm_pkg::LINE_BITS / 8;
    localparam int NLINES = CACHE_BYTES / LINE_BYTES;
    localparam int IDX_W = $clog2(NLINES);
    localparam int TAG_W = pcm_pkg::ADDR_W - pcm_pkg::OFS_W - IDX_W;
    localparam int SPAN_W = pcm_pkg::ICR_CNT_W + 2;
    localparam logic [SPAN_W-1:0] SPAN_RND = SPAN_W'(pcm_pkg::LINE_WORDS - 1);

    if (NLINES < 2 || (1 << IDX_W) != NLINES ||
            CACHE_BYTES % LINE_BYTES != 0) begin : g_chk
        $error("pcm_cache_top: cache size must be a power-of-two of lines");
    end

    function automatic logic [31:0] word_of(input logic [255:0] line,
            input logic [2:0] sel);
        return line[sel*pcm_pkg::WORD_BITS +: pcm_pkg::WORD_BITS];
    endfunction : word_of

    // reserved codes are served as bypass: never fill, never hit
    function automatic logic mode_fills(input logic [2:0] m);
        return m == pcm_pkg::MODE_EN || m == pcm_pkg::MODE_EN_OLD;
    endfunction : mode_fills

    function automatic logic mode_hits(input logic [2:0] m);
        return mode_fills(m) || m == pcm_pkg::MODE_FREEZE;
    endfunction : mode_hits

    function automatic logic [31:0] be_merge(input logic [31:0] old,
            input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // storage
    logic [NLINES-1:0] valid_q, valid_d;
    logic [TAG_W-1:0] tag_mem [NLINES];
    logic [pcm_pkg::LINE_BITS-1:0] data_mem [NLINES];
    logic fill_we;
    // fetch and fill state
    pcm_pkg::pcm_state_e state_q, state_d;
    logic ready_q, ready_d;
    logic fvalid_q, fvalid_d;
    logic [31:0] fdata_q, fdata_d;
    logic lreq_q, lreq_d;
    logic lgot_q, lgot_d;
    logic [31:0] laddr_q, laddr_d;
    logic [31:0] miss_q, miss_d;
    logic pend_q, pend_d;
    logic [IDX_W-1:0] inv_idx_q, inv_idx_d;
    logic [IDX_W:0] inv_left_q, inv_left_d;
    // bus registers
    logic [31:0] isar_q, isar_d;
    logic [31:0] icr_q, icr_d;
    logic [2:0] mode_q, mode_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic icr_wr;
    // arbiter
    logic [pcm_pkg::N_SRC-1:0] gnt_q, gnt, arb_req;
    logic [IDX_W-1:0] f_idx;
    logic [TAG_W-1:0] f_tag;
    logic f_hit;
    logic [IDX_W-1:0] m_idx;
    logic [SPAN_W-1:0] span;
    logic [IDX_W:0] inv_lines;
    logic busy;
    assign arb_req = {PER_REQ_I, lreq_q & ~lgot_q, DB_REQ_I, DA_REQ_I}
        & ~gnt_q;

    pcm_bank_arb #(
        .NSRC(pcm_pkg::N_SRC)
    ) u_arb (
        .req_i(arb_req),
        .addr_i({PER_ADDR_I, laddr_q, DB_ADDR_I, DA_ADDR_I}),
        .gnt_o(gnt)
    );

    always_comb begin
        f_idx = FETCH_ADDR_I[pcm_pkg::OFS_W +: IDX_W];
        f_tag = FETCH_ADDR_I[pcm_pkg::ADDR_W-1 -: TAG_W];
        m_idx = miss_q[pcm_pkg::OFS_W +: IDX_W];
        f_hit = valid_q[f_idx] && tag_mem[f_idx] == f_tag &&
            mode_hits(mode_q);
        span = SPAN_W'(isar_q[pcm_pkg::WSEL_LSB +: pcm_pkg::WSEL_W])
            + SPAN_W'(icr_q[pcm_pkg::ICR_CNT_W-1:0]) + SPAN_RND;
        if (icr_q[pcm_pkg::ICR_CNT_W-1:0] == '0) begin
            inv_lines = '0;
        end else if ((span >> pcm_pkg::WSEL_W) > SPAN_W'(NLINES)) begin
            inv_lines = (IDX_W+1)'(NLINES);
        end else begin
            inv_lines = (IDX_W+1)'(span >> pcm_pkg::WSEL_W);
        end
    end

    // register slave
    always_comb begin
        logic [31:0] merged;
        merged = 32'h0000_0000;
        busy = pend_q || state_q == pcm_pkg::ST_INV;
        // range registers hold still while an invalidate is owed
        wait_d = !((AVS_READ_I || AVS_WRITE_I) && wait_q &&
            !(AVS_WRITE_I && busy && (AVS_ADDRESS_I == pcm_pkg::ISAR_ADDR
            || AVS_ADDRESS_I == pcm_pkg::ICR_ADDR)));
        rdata_d = 32'h0000_0000;
        if (AVS_READ_I && wait_q) begin
            unique case (AVS_ADDRESS_I)
                pcm_pkg::ISAR_ADDR: rdata_d = isar_q;
                pcm_pkg::ICR_ADDR: rdata_d = icr_q;
                pcm_pkg::MODE_ADDR: begin
                    rdata_d[pcm_pkg::MODE_LSB +: pcm_pkg::MODE_W] = mode_q;
                end
                pcm_pkg::STAT_ADDR: begin
                    rdata_d[pcm_pkg::STAT_BUSY] =
                        state_q == pcm_pkg::ST_INV;
                    rdata_d[pcm_pkg::STAT_PEND] = pend_q;
                    rdata_d[pcm_pkg::MODE_LSB +: pcm_pkg::MODE_W] = mode_q;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        isar_d = isar_q;
        icr_d = icr_q;
        mode_d = mode_q;
        icr_wr = 1'b0;
        // a write takes effect at the edge where waitrequest is low
        if (AVS_WRITE_I && !wait_q) begin
            unique case (AVS_ADDRESS_I)
                pcm_pkg::ISAR_ADDR: begin
                    isar_d = be_merge(isar_q, AVS_WRITEDATA_I,
                        AVS_BYTEENABLE_I);
                end
                pcm_pkg::ICR_ADDR: begin
                    icr_d = be_merge(icr_q, AVS_WRITEDATA_I,
                        AVS_BYTEENABLE_I);
                    icr_wr = 1'b1;
                end
                pcm_pkg::MODE_ADDR: begin
                    merged = be_merge(32'h0000_0000, AVS_WRITEDATA_I,
                        AVS_BYTEENABLE_I);
                    if (AVS_BYTEENABLE_I[0]) begin
                        mode_d = merged[pcm_pkg::MODE_LSB +: pcm_pkg::MODE_W];
                    end
                end
                default: mode_d = mode_q;
            endcase
        end
    end

    // fetch, fill and invalidate sequencing
    always_comb begin
        state_d = state_q;
        valid_d = valid_q;
        ready_d = ready_q;
        fvalid_d = 1'b0;
        fdata_d = fdata_q;
        lreq_d = lreq_q;
        laddr_d = laddr_q;
        miss_d = miss_q;
        inv_idx_d = inv_idx_q;
        inv_left_d = inv_left_q;
        pend_d = pend_q | icr_wr;
        fill_we = 1'b0;
        unique case (state_q)
            pcm_pkg::ST_IDLE: begin
                if (FETCH_REQ_I && ready_q) begin
                    if (f_hit) begin
                        fvalid_d = 1'b1;
                        fdata_d = word_of(data_mem[f_idx],
                            FETCH_ADDR_I[pcm_pkg::WSEL_LSB +: pcm_pkg::WSEL_W]);
                        ready_d = !pend_d;
                    end else begin
                        miss_d = FETCH_ADDR_I;
                        lreq_d = 1'b1;
                        laddr_d = {FETCH_ADDR_I[31:pcm_pkg::OFS_W],
                            {pcm_pkg::OFS_W{1'b0}}};
                        ready_d = 1'b0;
                        state_d = pcm_pkg::ST_FILL;
                    end
                end else if (pend_q) begin
                    pend_d = 1'b0;
                    if (inv_lines != '0) begin
                        inv_idx_d = isar_q[pcm_pkg::OFS_W +: IDX_W];
                        inv_left_d = inv_lines;
                        ready_d = 1'b0;
                        state_d = pcm_pkg::ST_INV;
                    end else begin
                        ready_d = 1'b1;
                    end
                end else begin
                    ready_d = !pend_d;
                end
            end
            pcm_pkg::ST_FILL: begin
                if (LINE_VALID_I) begin
                    lreq_d = 1'b0;
                    fvalid_d = 1'b1;
                    fdata_d = word_of(LINE_DATA_I,
                        miss_q[pcm_pkg::WSEL_LSB +: pcm_pkg::WSEL_W]);
                    fill_we = mode_fills(mode_q);
                    if (fill_we) begin
                        valid_d[m_idx] = 1'b1;
                    end
                    ready_d = !pend_d;
                    state_d = pcm_pkg::ST_IDLE;
                end
            end
            pcm_pkg::ST_INV: begin
                valid_d[inv_idx_q] = 1'b0;
                inv_idx_d = IDX_W'(inv_idx_q + 1'b1);
                inv_left_d = (IDX_W+1)'(inv_left_q - 1'b1);
                if (inv_left_q == (IDX_W+1)'(1)) begin
                    ready_d = 1'b1;
                    state_d = pcm_pkg::ST_IDLE;
                end
            end
            default: begin
                ready_d = 1'b1;
                lreq_d = 1'b0;
                state_d = pcm_pkg::ST_IDLE;
            end
        endcase
        // a line grant is given once per fill request
        lgot_d = lreq_d & (lgot_q | gnt[pcm_pkg::SRC_LINE]);
    end

    always_ff @(posedge MCLK_I) begin
        if (fill_we) begin
            tag_mem[m_idx] <= miss_q[pcm_pkg::ADDR_W-1 -: TAG_W];
            data_mem[m_idx] <= LINE_DATA_I;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_q <= pcm_pkg::ST_IDLE;
            valid_q <= '0;
            ready_q <= 1'b1;
            fvalid_q <= 1'b0;
            fdata_q <= 32'h0000_0000;
            lreq_q <= 1'b0;
            lgot_q <= 1'b0;
            laddr_q <= 32'h0000_0000;
            miss_q <= 32'h0000_0000;
            pend_q <= 1'b0;
            inv_idx_q <= '0;
            inv_left_q <= '0;
            gnt_q <= '0;
        end else begin
            state_q <= state_d;
            valid_q <= valid_d;
            ready_q <= ready_d;
            fvalid_q <= fvalid_d;
            fdata_q <= fdata_d;
            lreq_q <= lreq_d;
            lgot_q <= lgot_d;
            laddr_q <= laddr_d;
            miss_q <= miss_d;
            pend_q <= pend_d;
            inv_idx_q <= inv_idx_d;
            inv_left_q <= inv_left_d;
            gnt_q <= gnt;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            isar_q <= 32'h0000_0000;
            icr_q <= 32'h0000_0000;
            mode_q <= pcm_pkg::MODE_RST;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            isar_q <= isar_d;
            icr_q <= icr_d;
            mode_q <= mode_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign AVS_READDATA_O = rdata_q;
    assign AVS_WAITREQUEST_O = wait_q;
    assign FETCH_READY_O = ready_q;
    assign FETCH_VALID_O = fvalid_q;
    assign FETCH_DATA_O = fdata_q;
    assign LINE_REQ_O = lreq_q;
    assign LINE_ADDR_O = laddr_q;
    assign LINE_GNT_O = gnt_q[pcm_pkg::SRC_LINE];
    assign DA_GNT_O = gnt_q[pcm_pkg::SRC_DA];
    assign DB_GNT_O = gnt_q[pcm_pkg::SRC_DB];
    assign PER_GNT_O = gnt_q[pcm_pkg::SRC_PER];
endmodule : pcm_cache_top

// ### src/pcm_pkg.sv
// Purpose: shared constants and types of the program cache and memory arbiter
// Assumes: 32-bit byte addresses, one clock domain
// Notes: register offsets are Avalon byte addresses
package pcm_pkg;
    localparam int ADDR_W = 32;
    localparam int WORD_BITS = 32;
    localparam int LINE_BITS = 256;
    localparam int LINE_WORDS = 8;
    localparam int OFS_W = 5;
    localparam int WSEL_LSB = 2;
    localparam int WSEL_W = 3;
    localparam int CACHE_BYTES = 32768;

    localparam logic [31:0] ISAR_ADDR = 32'h2000_0000;
    localparam logic [31:0] ICR_ADDR = 32'h2000_0004;
    localparam logic [31:0] MODE_ADDR = 32'h2000_0008;
    localparam logic [31:0] STAT_ADDR = 32'h2000_000c;

    localparam int MODE_LSB = 5;
    localparam int MODE_W = 3;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [2:0] MODE_EN_OLD = 3'h0;
    localparam logic [2:0] MODE_EN = 3'h2;
    localparam logic [2:0] MODE_FREEZE = 3'h3;
    localparam logic [2:0] MODE_BYPASS = 3'h4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PEND = 1;
    localparam int ICR_CNT_W = 16;

    localparam int N_SRC = 4;
    localparam int MAX_GRANTS = 3;
    localparam int SRC_DA = 0;
    localparam int SRC_DB = 1;
    localparam int SRC_LINE = 2;
    localparam int SRC_PER = 3;
    localparam logic [3:0] SRC_WIDE = 4'h3;

    localparam int N_PAGE = 4;
    localparam int N_BANK = 8;
    localparam logic [1:0] PG_ROM0 = 2'h0;
    localparam logic [1:0] PG_ROM1 = 2'h1;
    localparam logic [1:0] PG_RAM = 2'h2;
    localparam logic [1:0] PG_EXT = 2'h3;
    localparam int RGN_LSB = 28;
    localparam logic [3:0] RGN_ROM = 4'h0;
    localparam logic [3:0] RGN_RAM = 4'h1;
    localparam int ROM_PG_BIT = 18;
    localparam int B64_LSB = 3;
    localparam int B32_LSB = 2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FILL = 3'b010,
        ST_INV = 3'b100
    } pcm_state_e;
endpackage : pcm_pkg

// ### src/pcm_bank_arb.sv
// Purpose: page and bank conflict arbiter of the on-chip memory controller
// Assumes: requests and addresses come from logic on the same clock
// Notes: purely combinational; the caller registers the grants
`timescale 1ns/1ps
module pcm_bank_arb #(
    parameter int NSRC = pcm_pkg::N_SRC
) (
    input wire logic [NSRC-1:0] req_i,
    input wire logic [NSRC*pcm_pkg::ADDR_W-1:0] addr_i,
    output logic [NSRC-1:0] gnt_o
);
    if (NSRC != pcm_pkg::N_SRC) begin : g_chk
        $error("pcm_bank_arb: source count is fixed");
    end

    function automatic logic [1:0] page_of(input logic [31:0] a);
        logic [1:0] p;
        p = pcm_pkg::PG_EXT;
        if (a[31:pcm_pkg::RGN_LSB] == pcm_pkg::RGN_ROM) begin
            p = a[pcm_pkg::ROM_PG_BIT] ? pcm_pkg::PG_ROM1 : pcm_pkg::PG_ROM0;
        end else if (a[31:pcm_pkg::RGN_LSB] == pcm_pkg::RGN_RAM) begin
            p = pcm_pkg::PG_RAM;
        end
        return p;
    endfunction : page_of

    // rom banks are 64 bits wide and take two mask bits each
    function automatic logic [7:0] bank_mask(input logic [1:0] p,
            input logic [31:0] a, input logic wide);
        logic [7:0] m;
        logic [2:0] b;
        m = 8'h00;
        b = {a[pcm_pkg::OFS_W-1:pcm_pkg::B64_LSB], 1'b0};
        if (p == pcm_pkg::PG_RAM && !wide) begin
            m = 8'h01 << a[pcm_pkg::OFS_W-1:pcm_pkg::B32_LSB];
        end else if (p != pcm_pkg::PG_EXT) begin
            m = 8'h03 << b;
        end
        return m;
    endfunction : bank_mask

    always_comb begin
        logic [pcm_pkg::N_PAGE-1:0][pcm_pkg::N_BANK-1:0] used;
        logic [pcm_pkg::N_PAGE-1:0] line_pg;
        logic [1:0] p;
        logic [7:0] m;
        logic busy;
        int n;
        used = '0;
        line_pg = '0;
        p = pcm_pkg::PG_EXT;
        m = 8'h00;
        busy = 1'b0;
        n = 0;
        gnt_o = '0;
        for (int i = 0; i < NSRC; i++) begin
            p = page_of(addr_i[i*pcm_pkg::ADDR_W +: pcm_pkg::ADDR_W]);
            m = bank_mask(p, addr_i[i*pcm_pkg::ADDR_W +: pcm_pkg::ADDR_W],
                pcm_pkg::SRC_WIDE[i]);
            if (i == pcm_pkg::SRC_LINE) begin
                busy = (|used[p]) | line_pg[p];
            end else begin
                busy = (|(used[p] & m)) | line_pg[p];
            end
            if (req_i[i] && !busy && n < pcm_pkg::MAX_GRANTS) begin
                gnt_o[i] = 1'b1;
                n = n + 1;
                used[p] = used[p] | m;
                if (i == pcm_pkg::SRC_LINE && p != pcm_pkg::PG_EXT) begin
                    line_pg[p] = 1'b1;
                end
            end
        end
    end
endmodule : pcm_bank_arb

// ### tb/pcm_cache_assertions.sv
// Purpose: port-level checks of the program cache
// Assumes: one clock, async active-low reset
// Notes: bound to pcm_cache_top
`timescale 1ns/1ps
module pcm_cache_assertions (
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic FETCH_REQ_I,
    input wire logic FETCH_READY_O,
    input wire logic FETCH_VALID_O,
    input wire logic LINE_REQ_O,
    input wire logic [31:0] LINE_ADDR_O,
    input wire logic LINE_GNT_O,
    input wire logic LINE_VALID_I,
    input wire logic DA_REQ_I,
    input wire logic DA_GNT_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESETN_I);

    chk_wait_pulse: assert property (
        !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low two cycles");
    chk_fetch_answer: assert property (
        FETCH_REQ_I && FETCH_READY_O |=> FETCH_VALID_O || LINE_REQ_O)
        else $error("taken fetch neither hit nor missed");
    chk_fill_penalty: assert property (
        LINE_VALID_I |=> FETCH_VALID_O)
        else $error("fill not answered next cycle");
    chk_line_hold: assert property (
        LINE_REQ_O && !LINE_VALID_I |=> LINE_REQ_O && $stable(LINE_ADDR_O))
        else $error("line request dropped early");
    chk_line_align: assert property (
        LINE_REQ_O |-> LINE_ADDR_O[4:0] == 5'h0)
        else $error("line address not aligned");
    chk_miss_stall: assert property (
        LINE_REQ_O |-> !FETCH_READY_O)
        else $error("fetch ready during fill");
    chk_gnt_pulse: assert property (
        DA_GNT_O |=> !DA_GNT_O)
        else $error("grant longer than one cycle");
    chk_da_first: assert property (
        DA_REQ_I && !DA_GNT_O |=> DA_GNT_O)
        else $error("top priority port not granted");
    chk_line_gnt: assert property (
        LINE_GNT_O |-> LINE_REQ_O)
        else $error("line grant without request");

    cover property (LINE_VALID_I ##1 FETCH_VALID_O);
    cover property (FETCH_REQ_I && FETCH_READY_O ##1 FETCH_VALID_O);
    cover property (DA_REQ_I ##1 DA_GNT_O);
endmodule : pcm_cache_assertions

bind pcm_cache_top pcm_cache_assertions pcm_cache_assertions_inst (
    .MCLK_I(MCLK_I), .RESETN_I(RESETN_I),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .FETCH_REQ_I(FETCH_REQ_I),
    .FETCH_READY_O(FETCH_READY_O), .FETCH_VALID_O(FETCH_VALID_O),
    .LINE_REQ_O(LINE_REQ_O), .LINE_ADDR_O(LINE_ADDR_O),
    .LINE_GNT_O(LINE_GNT_O), .LINE_VALID_I(LINE_VALID_I),
    .DA_REQ_I(DA_REQ_I), .DA_GNT_O(DA_GNT_O)
);

// ### tb/pcm_line_mem.sv
// Purpose: line memory behind the cache fill port
// Assumes: answers only a granted line request
// Notes: each word holds its own byte address
`timescale 1ns/1ps
module pcm_line_mem (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] line_addr_i,
    input wire logic line_gnt_i,
    input wire logic [3:0] slow_i,
    output logic line_valid_o,
    output logic [255:0] line_data_o
);
    logic pend_q;
    logic [3:0] cnt_q;
    logic [7:0] noise_q;
    assign line_valid_o = (slow_i == 4'h0) ? line_gnt_i :
                          (pend_q && cnt_q == 4'h0);
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            line_data_o[32*n +: 32] = line_valid_o ?
                {line_addr_i[31:5], 3'(n), 2'h0} : {4{noise_q}};
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= 1'b0;
            cnt_q <= 4'h0;
            noise_q <= 8'h0;
        end else begin
            noise_q <= noise_q + 8'h1;
            if (line_gnt_i && slow_i != 4'h0) begin
                pend_q <= 1'b1;
                cnt_q <= slow_i - 4'h1;
            end else if (pend_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else begin
                pend_q <= 1'b0;
            end
        end
    end
endmodule : pcm_line_mem

// ### tb/tb_pcm_cache_top.sv
// Purpose: self-checking bench of the program cache
// Assumes: 1 KB cache so aliasing is cheap to reach
// Notes: fetch latency counts edges after the request is taken
`timescale 1ns/1ps
module tb_pcm_cache_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] avs_addr = 32'h0;
    logic [31:0] avs_wd = 32'h0;
    logic avs_rd = 1'b0;
    logic avs_wr = 1'b0;
    logic [3:0] avs_be = 4'hf;
    logic [31:0] avs_rdata, f_data, l_addr, rd;
    logic avs_wait, f_rdy, f_vld, l_req, l_gnt, l_vld, da_g, db_g, per_g;
    logic f_req = 1'b0;
    logic [31:0] f_addr = 32'h0;
    logic [255:0] l_data;
    logic [2:0] d_req = 3'h0;
    logic [31:0] d_addr [3] = '{default: 32'h0};
    logic [3:0] slow = 4'h0;
    wire [2:0] g = {per_g, db_g, da_g};
    int fail_count = 0;
    int samples_checked = 0;

    pcm_cache_top #(.CACHE_BYTES(1024)) pcm_cache_top_inst (
        .MCLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(avs_addr),
        .AVS_READ_I(avs_rd), .AVS_WRITE_I(avs_wr),
        .AVS_WRITEDATA_I(avs_wd), .AVS_BYTEENABLE_I(avs_be),
        .AVS_READDATA_O(avs_rdata), .AVS_WAITREQUEST_O(avs_wait),
        .FETCH_REQ_I(f_req), .FETCH_ADDR_I(f_addr),
        .FETCH_READY_O(f_rdy), .FETCH_VALID_O(f_vld),
        .FETCH_DATA_O(f_data), .LINE_REQ_O(l_req),
        .LINE_ADDR_O(l_addr), .LINE_GNT_O(l_gnt),
        .LINE_VALID_I(l_vld), .LINE_DATA_I(l_data),
        .DA_REQ_I(d_req[0]), .DA_ADDR_I(d_addr[0]), .DA_GNT_O(da_g),
        .DB_REQ_I(d_req[1]), .DB_ADDR_I(d_addr[1]), .DB_GNT_O(db_g),
        .PER_REQ_I(d_req[2]), .PER_ADDR_I(d_addr[2]), .PER_GNT_O(per_g)
    );
    pcm_line_mem pcm_line_mem_inst (
        .clk_i(clk), .rst_n_i(rst_n), .line_addr_i(l_addr),
        .line_gnt_i(l_gnt), .slow_i(slow), .line_valid_o(l_vld),
        .line_data_o(l_data)
    );

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic results();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // idle edge at the end keeps strobes from being set twice in one step
    task automatic avs(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        avs_addr <= a;
        avs_wd <= d;
        avs_be <= be;
        avs_rd <= !wr;
        avs_wr <= wr;
        do @(posedge clk); while (avs_wait !== 1'b0);
        rd = avs_rdata;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
        @(posedge clk);
    endtask : avs

    task automatic fetch(input logic [31:0] a, input int lat);
        int n;
        n = 0;
        f_req <= 1'b1;
        f_addr <= a;
        do @(posedge clk); while (f_rdy !== 1'b1);
        f_req <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (f_vld !== 1'b1 && n < 40);
        check("fetch latency", 32'(n), 32'(lat));
        check("fetch data", f_data, {a[31:2], 2'h0});
    endtask : fetch

    task automatic arb(input logic [31:0] a, b, p, input int ea, eb, ep);
        int k [3];
        k = '{0, 0, 0};
        d_addr <= '{a, b, p};
        d_req <= 3'h7;
        for (int c = 1; c < 8; c++) begin
            @(posedge clk);
            for (int s = 0; s < 3; s++) begin
                if (g[s] === 1'b1 && k[s] == 0) begin
                    k[s] = c;
                    d_req[s] <= 1'b0;
                end
            end
        end
        check("port a grant", 32'(k[0]), 32'(ea));
        check("port b grant", 32'(k[1]), 32'(eb));
        check("periph grant", 32'(k[2]), 32'(ep));
    endtask : arb

    task automatic t_reset();
        check("wait idle", 32'(avs_wait), 32'h1);
        check("ready idle", 32'(f_rdy), 32'h1);
        avs(1'b0, pcm_pkg::MODE_ADDR, 32'h0, 4'hf);
        check("mode reset", rd, 32'h0);
        avs(1'b0, pcm_pkg::ISAR_ADDR, 32'h0, 4'hf);
        check("start reset", rd, 32'h0);
        avs(1'b0, 32'h2000_0010, 32'h0, 4'hf);
        check("unmapped read", rd, 32'h0);
        avs(1'b1, pcm_pkg::ISAR_ADDR, 32'h104, 4'hf);
        avs(1'b0, pcm_pkg::ISAR_ADDR, 32'h0, 4'hf);
        check("start rw", rd, 32'h104);
    endtask : t_reset

    task automatic t_fill();
        fetch(32'h0000_0104, 3);
        fetch(32'h0000_011c, 1);
        fetch(32'h1000_0020, 3);
        fetch(32'h8000_0044, 3);
        fetch(32'h8000_0040, 1);
        slow <= 4'h3;
        fetch(32'h0000_0500, 6);
        slow <= 4'h0;
        fetch(32'h0000_0104, 3);
    endtask : t_fill

    // lane 0 off leaves the reserved code in place, so it still bypasses
    task automatic t_modes();
        logic [2:0] md [8] = '{3'h2, 3'h3, 3'h3, 3'h3,
                               3'h4, 3'h7, 3'h2, 3'h2};
        logic [3:0] be [8] = '{4'hf, 4'hf, 4'hf, 4'hf,
                               4'hf, 4'hf, 4'he, 4'hf};
        logic [31:0] ad [8] = '{32'h104, 32'h300, 32'h300, 32'h104,
                                32'h104, 32'h104, 32'h104, 32'h104};
        int lt [8] = '{1, 3, 3, 1, 3, 3, 3, 1};
        for (int i = 0; i < 8; i++) begin
            avs(1'b1, pcm_pkg::MODE_ADDR, {24'h0, md[i], 5'h0}, be[i]);
            fetch(ad[i], lt[i]);
        end
        avs(1'b0, pcm_pkg::MODE_ADDR, 32'h0, 4'hf);
        check("mode field", {29'h0, rd[7:5]}, 32'h2);
    endtask : t_modes

    task automatic t_inval();
        avs(1'b1, pcm_pkg::ISAR_ADDR, 32'h11c, 4'hf);
        avs(1'b1, pcm_pkg::ICR_ADDR, 32'h0, 4'hf);
        fetch(32'h104, 1);
        avs(1'b1, pcm_pkg::ICR_ADDR, 32'h1, 4'hf);
        fetch(32'h104, 3);
        fetch(32'h8000_0040, 1);
        avs(1'b1, pcm_pkg::ICR_ADDR, 32'hffff, 4'hf);
        avs(1'b0, pcm_pkg::STAT_ADDR, 32'h0, 4'hf);
        check("inval busy", {30'h0, rd[1:0]}, 32'h1);
        avs(1'b1, pcm_pkg::ISAR_ADDR, 32'h0, 4'hf);
        avs(1'b0, pcm_pkg::STAT_ADDR, 32'h0, 4'hf);
        check("inval idle", {30'h0, rd[1:0]}, 32'h0);
        fetch(32'h8000_0040, 3);
    endtask : t_inval

    task automatic t_arb();
        arb(32'h1000_0000, 32'h1000_0008, 32'h1000_0010, 2, 2, 2);
        arb(32'h1000_0000, 32'h1000_0000, 32'h0004_0000, 2, 3, 2);
        arb(32'h0000_0000, 32'h0004_0000, 32'h0000_0000, 2, 2, 3);
        arb(32'h0000_0000, 32'h0000_0010, 32'h1000_0000, 2, 2, 2);
    endtask : t_arb

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_fill();
        t_modes();
        t_inval();
        t_arb();
        results();
    end

    // the whole run needs a few hundred cycles; 10000 means a hang
    initial begin
        #200000;
        fail_count++;
        results();
    end
endmodule : tb_pcm_cache_top
